// ---- hbmc_top.sv ----
// Memory cache between the host bus slave port and the byte-wide buffer RAM.
// Assumes host strobes are asynchronous and RAM read data return one cycle
// after the read strobe; a granted RAM write completes in its own cycle.
//
// How it works
// R1: one four-byte FIFO serves reads and writes
// R2: host counter compares, buffer counter addresses RAM
// R3: read miss loads counters, fills bytewise
// R4: channel-ready low during fill, high when ready
// R5: host counter steps one or two per access
// R6: read mode prefetches while FIFO has room
// R7: read hit with valid data served at once
// R8: writes posted into FIFO, drained when RAM free
// R9: write miss flushes FIFO before counter load
// R10: channel-ready driven only during board access
// R11: zero-wait on mode, address, data/room match, or for writes per R12
// R12: writes zero-wait in read mode or empty
// R13: zero-wait enable clear blocks zero-wait always
// R14: zero-wait gated by widths, enable, slot size
// R15: staggered bit forces buffer address odd on miss
// R16: software starts staggered transfers at even address
// R17: byte and word host access over byte RAM
// R18: direction change handled as a miss
module hbmc_top
	import hbmc_pkg::*;
(
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	// Register port
	input  wire logic [REG_ADDR_W-1:0] reg_addr,
	input  wire logic [REG_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [REG_DATA_W-1:0] reg_rdata,
	// Host bus
	input  wire logic [ADDR_W-1:0]     host_addr,
	input  wire logic [15:0]           host_wdata,
	input  wire logic                  host_rd_n,
	input  wire logic                  host_wr_n,
	input  wire logic                  host_word,
	input  wire logic                  slot_16bit,
	input  wire logic                  mem_16bit,
	output logic      [15:0]           host_rdata,
	output logic                       chrdy_o,
	output logic                       chrdy_oe,
	output logic                       zws_n,
	// Buffer RAM
	input  wire logic                  ram_grant,
	input  wire logic [BYTE_W-1:0]     ram_rdata,
	output logic      [ADDR_W-1:0]     ram_addr,
	output logic      [BYTE_W-1:0]     ram_wdata,
	output logic                       ram_we,
	output logic                       ram_re
);

	// Byte count of one host access
	function automatic logic [LVL_W-1:0] access_bytes(input logic word);
		access_bytes = word ? STEP_WORD : STEP_BYTE;
	endfunction

	// Counter step with wrap inside the address space
	function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] a,
	                                                 input logic [LVL_W-1:0] n);
		addr_step = a + ADDR_W'(n);
	endfunction

	hbmc_fifo_if #(.W(BYTE_W), .L(LVL_W)) fq ();

	hbmc_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (CACHE_DEPTH)
	) u_fifo (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.f       (fq.fifo)
	);

	// State
	hbmc_state_t        state_reg;
	hbmc_state_t        state_next;
	logic [CTRL_W-1:0]  ctrl_reg;
	logic [PIN_SYNC-1:0] rd_sync_reg;
	logic [PIN_SYNC-1:0] wr_sync_reg;
	logic               rd_filt_n_reg;
	logic               wr_filt_n_reg;
	logic [ADDR_W-1:0]  host_cnt_reg;
	logic [ADDR_W-1:0]  buf_cnt_reg;
	logic               cnt_valid_reg;
	logic               mode_wr_reg;
	logic               pend_reg;
	logic               req_wr_reg;
	logic               word_reg;
	logic               idx_reg;
	logic [ADDR_W-1:0]  addr_reg;
	logic [15:0]        wdata_reg;
	logic [15:0]        rdata_reg;
	logic               zws_reg;
	logic [REG_DATA_W-1:0] reg_rdata_reg;

	// Decoded terms
	wire                rd_act;
	wire                wr_act;
	wire                strobe_act;
	wire                req_wr;
	wire [LVL_W-1:0]    req_bytes;
	wire [LVL_W-1:0]    cur_bytes;
	wire                addr_hit;
	wire                mode_hit;
	wire                have_room;
	wire                have_data;
	wire                data_ok;
	wire                hit;
	wire                start;
	wire                flush_first;
	wire                load_idle;
	wire                load_flush;
	wire                load;
	wire [ADDR_W-1:0]   load_addr;
	wire                load_wr;
	wire [ADDR_W-1:0]   buf_load;
	wire                fill_ready;
	wire                host_push;
	wire                host_pop;
	wire                xfer_step;
	wire                xfer_last;
	wire [LVL_W:0]      inflight;
	wire                zws_cond;
	wire                zws_width_ok;
	wire                zws_set;
	wire [BYTE_W-1:0]   push_byte;

	// Host strobe filter: three stages, change taken when last two agree
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rd_sync_reg   <= '1;
			wr_sync_reg   <= '1;
			rd_filt_n_reg <= 1'b1;
			wr_filt_n_reg <= 1'b1;
		end else begin
			rd_sync_reg <= {rd_sync_reg[PIN_SYNC-2:0], host_rd_n};
			wr_sync_reg <= {wr_sync_reg[PIN_SYNC-2:0], host_wr_n};
			if (rd_sync_reg[1] == rd_sync_reg[2])
				rd_filt_n_reg <= rd_sync_reg[2];
			if (wr_sync_reg[1] == wr_sync_reg[2])
				wr_filt_n_reg <= wr_sync_reg[2];
		end
	end

	// Access decode and hit test
	assign rd_act     = ~rd_filt_n_reg;
	assign wr_act     = ~wr_filt_n_reg;
	assign strobe_act = rd_act | wr_act;
	assign req_wr     = wr_act & ~rd_act;
	assign req_bytes  = access_bytes(host_word);                      // R17
	assign cur_bytes  = access_bytes(word_reg);
	assign addr_hit   = cnt_valid_reg && (host_addr == host_cnt_reg);  // R2
	assign mode_hit   = (req_wr == mode_wr_reg);                       // R18
	assign have_room  = ({1'b0, fq.level} + {1'b0, req_bytes}) <= (LVL_W+1)'(CACHE_DEPTH);
	assign have_data  = (fq.level >= req_bytes);
	assign data_ok    = req_wr ? have_room : have_data;
	assign hit        = addr_hit & mode_hit;                           // R7
	assign start      = (state_reg == H_IDLE) & strobe_act;

	// Miss handling: write data is drained before any counter load
	assign flush_first = mode_wr_reg & (fq.level != '0);               // R9
	assign load_idle   = start & ~hit & ~flush_first;                  // R3 R18
	assign load_flush  = (state_reg == H_FLUSH) & (fq.level == '0);    // R9
	assign load        = load_idle | load_flush;
	assign load_addr   = (state_reg == H_IDLE) ? host_addr : addr_reg;
	assign load_wr     = (state_reg == H_IDLE) ? req_wr : req_wr_reg;
	assign buf_load    = {load_addr[ADDR_W-1:1],
	                      load_addr[0] | ctrl_reg[CTRL_ODD]};          // R15

	// Fill wait, then one byte per cycle between host and FIFO
	assign fill_ready = req_wr_reg ?
		(({1'b0, fq.level} + {1'b0, cur_bytes}) <= (LVL_W+1)'(CACHE_DEPTH)) :
		(fq.level >= cur_bytes);
	assign host_push  = (state_reg == H_XFER) & mode_wr_reg & fq.push_ready;  // R8
	assign host_pop   = (state_reg == H_XFER) & ~mode_wr_reg & fq.pop_valid;
	assign xfer_step  = host_push | host_pop;
	assign xfer_last  = ~word_reg | idx_reg;
	assign push_byte  = idx_reg ? wdata_reg[15:8] : wdata_reg[7:0];

	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			H_IDLE: begin
				if (start)
					state_next = (~hit & flush_first) ? H_FLUSH : H_FILL;
			end
			H_FLUSH: begin
				if (load_flush)
					state_next = H_FILL;
			end
			H_FILL: begin
				if (fill_ready)
					state_next = H_XFER;
			end
			H_XFER: begin
				if (xfer_step && xfer_last)
					state_next = H_DONE;
			end
			H_DONE: begin
				if (!strobe_act)
					state_next = H_IDLE;                               // R10
			end
			default: state_next = H_IDLE;
		endcase
	end

	// Sequencer register
	always_ff @(posedge mclk) begin
		if (sys_rst)
			state_reg <= H_IDLE;
		else
			state_reg <= state_next;
	end

	// Access capture at the start of a board access
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			req_wr_reg <= 1'b0;
			word_reg   <= 1'b0;
			addr_reg   <= '0;
			wdata_reg  <= '0;
		end else if (start) begin
			req_wr_reg <= req_wr;
			word_reg   <= host_word;
			addr_reg   <= host_addr;
			wdata_reg  <= host_wdata;
		end
	end

	// Byte index and read data assembly
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			idx_reg   <= 1'b0;
			rdata_reg <= '0;
		end else if (start) begin
			idx_reg   <= 1'b0;
			rdata_reg <= '0;
		end else if (xfer_step) begin
			idx_reg <= ~idx_reg;
			if (host_pop && idx_reg)
				rdata_reg[15:8] <= fq.pop_data;
			else if (host_pop)
				rdata_reg[7:0] <= fq.pop_data;
		end
	end

	// Host counter and cache mode; load wins over the step
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			host_cnt_reg  <= '0;
			cnt_valid_reg <= 1'b0;
			mode_wr_reg   <= 1'b0;
		end else if (load) begin
			host_cnt_reg  <= load_addr;                                // R3
			cnt_valid_reg <= 1'b1;
			mode_wr_reg   <= load_wr;                                  // R18
		end else if (xfer_step && xfer_last) begin
			host_cnt_reg <= addr_step(host_cnt_reg, cur_bytes);        // R5
		end
	end

	// RAM engine: prefetch in read mode, drain in write mode
	assign inflight    = {1'b0, fq.level} + {{LVL_W{1'b0}}, pend_reg};
	assign ram_re      = ~mode_wr_reg & cnt_valid_reg & ram_grant & ~load &
	                     (inflight < (LVL_W+1)'(CACHE_DEPTH));         // R6
	assign ram_we      = mode_wr_reg & cnt_valid_reg & ram_grant & fq.pop_valid;  // R8
	assign ram_addr    = buf_cnt_reg;
	assign ram_wdata   = fq.pop_data;

	// FIFO steering by mode, one queue for both directions
	assign fq.clear      = load;                                       // R1 R3
	assign fq.push_valid = mode_wr_reg ? host_push : pend_reg;
	assign fq.push_data  = mode_wr_reg ? push_byte : ram_rdata;
	assign fq.pop_ready  = mode_wr_reg ? ram_we : host_pop;

	// Buffer counter and outstanding RAM read
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			buf_cnt_reg <= '0;
			pend_reg    <= 1'b0;
		end else begin
			pend_reg <= ram_re;                                        // R6
			if (load)
				buf_cnt_reg <= buf_load;                               // R15
			else if (ram_re || ram_we)
				buf_cnt_reg <= addr_step(buf_cnt_reg, STEP_BYTE);      // R3 R8
		end
	end

	// Zero-wait decision, taken once per access
	assign zws_cond = (hit & data_ok) |                                // R11
	                  (req_wr & (~mode_wr_reg | (fq.level == '0)));    // R12
	assign zws_width_ok = ~host_word |
	                      (ctrl_reg[CTRL_WIDE] & slot_16bit & mem_16bit);  // R14
	assign zws_set = start & ctrl_reg[CTRL_ZWAIT] & zws_cond & zws_width_ok;  // R13

	// Zero-wait flag holds for the access, drops when strobes end or the zero-wait enable clears
	always_ff @(posedge mclk) begin
		if (sys_rst)
			zws_reg <= 1'b0;
		else if (zws_set)
			zws_reg <= 1'b1;
		else if (state_reg == H_IDLE || !ctrl_reg[CTRL_ZWAIT])
			zws_reg <= 1'b0;                                           // R13
	end

	// Host side outputs
	assign zws_n      = ~zws_reg;
	assign chrdy_oe   = (state_reg != H_IDLE);                         // R10
	assign chrdy_o    = (state_reg == H_DONE);                         // R4
	assign host_rdata = rdata_reg;

	// Control register write
	always_ff @(posedge mclk) begin
		if (sys_rst)
			ctrl_reg <= CTRL_RESET;
		else if (reg_wr && reg_addr == OFS_CTRL)
			ctrl_reg <= reg_wdata[CTRL_W-1:0];
	end

	// Register read mux, unmapped offsets read zero
	wire [REG_DATA_W-1:0] status_word;
	wire [REG_DATA_W-1:0] rd_mux;
	assign status_word = {{(REG_DATA_W-STAT_LVL_LO-LVL_W){1'b0}}, fq.level,
	                      1'b0, cnt_valid_reg, (state_reg != H_IDLE), mode_wr_reg};
	assign rd_mux = (reg_addr == OFS_CTRL)    ? {{(REG_DATA_W-CTRL_W){1'b0}}, ctrl_reg} :
	                (reg_addr == OFS_STATUS)  ? status_word :
	                (reg_addr == OFS_HOSTCNT) ? host_cnt_reg :
	                (reg_addr == OFS_BUFCNT)  ? buf_cnt_reg : '0;

	// Read data stand for one cycle after the strobe only
	always_ff @(posedge mclk) begin
		if (sys_rst)
			reg_rdata_reg <= '0;
		else
			reg_rdata_reg <= reg_rd ? rd_mux : '0;
	end

	assign reg_rdata = reg_rdata_reg;

endmodule

// ---- hbmc_pkg.sv ----
// Shared constants for the host buffer memory cache.
// Assumes a single 10 MHz clock domain and a byte-wide local buffer RAM.
package hbmc_pkg;

	// Cache geometry
	localparam int          CACHE_DEPTH = 4;
	localparam int          BYTE_W      = 8;
	localparam int          ADDR_W      = 16;
	localparam int          LVL_W       = 3;
	localparam int          PIN_SYNC    = 3;

	// Register port geometry
	localparam int          REG_ADDR_W  = 4;
	localparam int          REG_DATA_W  = 16;

	// Register offsets
	localparam logic [3:0]  OFS_CTRL    = 4'h0;
	localparam logic [3:0]  OFS_STATUS  = 4'h1;
	localparam logic [3:0]  OFS_HOSTCNT = 4'h2;
	localparam logic [3:0]  OFS_BUFCNT  = 4'h3;

	// Control register fields
	localparam int          CTRL_ZWAIT  = 0;
	localparam int          CTRL_ODD    = 1;
	localparam int          CTRL_WIDE   = 2;
	localparam int          CTRL_W      = 3;
	localparam logic [2:0]  CTRL_RESET  = 3'h0;

	// Status register fields
	localparam int          STAT_MODE   = 0;
	localparam int          STAT_BUSY   = 1;
	localparam int          STAT_VALID  = 2;
	localparam int          STAT_LVL_LO = 4;

	// Access sizes in bytes
	localparam logic [2:0]  STEP_BYTE   = 3'h1;
	localparam logic [2:0]  STEP_WORD   = 3'h2;

	// Host access sequencer, Gray coded along the usual path
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_FLUSH = 3'b100,
		H_FILL  = 3'b001,
		H_XFER  = 3'b011,
		H_DONE  = 3'b010
	} hbmc_state_t;

endpackage

// ---- hbmc_fifo_if.sv ----
// Handshake bundle between the cache control and its byte FIFO.
// Assumes both ends run on the same clock.
interface hbmc_fifo_if #(
	parameter int W = 8,
	parameter int L = 3
);
	logic         clear;
	logic         push_valid;
	logic         push_ready;
	logic [W-1:0] push_data;
	logic         pop_valid;
	logic         pop_ready;
	logic [W-1:0] pop_data;
	logic [L-1:0] level;

	modport fifo (
		input  clear,
		input  push_valid,
		input  push_data,
		input  pop_ready,
		output push_ready,
		output pop_valid,
		output pop_data,
		output level
	);

	modport user (
		output clear,
		output push_valid,
		output push_data,
		output pop_ready,
		input  push_ready,
		input  pop_valid,
		input  pop_data,
		input  level
	);
endinterface

// ---- hbmc_fifo.sv ----
// Byte FIFO with valid/ready on both sides and a synchronous clear.
// Assumes the level field of the bundle is wide enough for DEPTH.
module hbmc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic   mclk,
	input wire logic   sys_rst,
	// Queue ports
	hbmc_fifo_if.fifo  f
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	wire              do_push;
	wire              do_pop;

	// Pointer step with wrap for any depth
	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	// Handshake terms
	assign f.push_ready = (count_reg != CW'(DEPTH));
	assign f.pop_valid  = (count_reg != '0);
	assign f.pop_data   = mem_reg[rd_ptr_reg];
	assign f.level      = count_reg;
	assign do_push      = f.push_valid & f.push_ready;
	assign do_pop       = f.pop_valid & f.pop_ready;

	// Storage write
	always_ff @(posedge mclk) begin
		if (do_push && !f.clear)
			mem_reg[wr_ptr_reg] <= f.push_data;
	end

	// Pointers and fill count, clear wins
	always_ff @(posedge mclk) begin
		if (sys_rst || f.clear) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (do_push)
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			if (do_pop)
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule

// ---- hbmc_ram_model.sv ----
// Behavioural byte-wide buffer RAM on the far side of the cache.
// Assumes the bench drives the grant; data stand one cycle after a read strobe.
module hbmc_ram_model
	import hbmc_pkg::*;
(
	// Clock
	input  wire logic              mclk,
	// RAM port
	input  wire logic [ADDR_W-1:0] ram_addr,
	input  wire logic [BYTE_W-1:0] ram_wdata,
	input  wire logic              ram_we,
	input  wire logic              ram_re,
	output logic      [BYTE_W-1:0] ram_rdata
);
	logic [BYTE_W-1:0] mem [0:65535];

	// Known pattern: low address byte xor 5a
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5a;
	end

	// One byte per strobe; stale data inverted so nothing reads as held
	always @(posedge mclk) begin
		if (ram_we) mem[ram_addr] <= ram_wdata;
		if (ram_re) ram_rdata <= mem[ram_addr];
		else ram_rdata <= ~ram_rdata;
	end
endmodule

// ---- hbmc_chk.sv ----
// Port-level checker for the host buffer memory cache.
// Assumes one clock and a synchronous active-high reset; bound to the top.
module hbmc_chk
	import hbmc_pkg::*;
(
	// Clock and reset
	input wire logic                  mclk, sys_rst,
	// Register port
	input wire logic [REG_ADDR_W-1:0] reg_addr,
	input wire logic [REG_DATA_W-1:0] reg_wdata, reg_rdata,
	input wire logic                  reg_wr, reg_rd,
	// Host bus
	input wire logic [ADDR_W-1:0]     host_addr,
	input wire logic [15:0]           host_wdata, host_rdata,
	input wire logic                  host_rd_n, host_wr_n, host_word, slot_16bit, mem_16bit,
	input wire logic                  chrdy_o, chrdy_oe, zws_n,
	// Buffer RAM
	input wire logic                  ram_grant, ram_we, ram_re,
	input wire logic [BYTE_W-1:0]     ram_rdata, ram_wdata,
	input wire logic [ADDR_W-1:0]     ram_addr
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	logic [CTRL_W-1:0] ctl_reg;

	// Shadow of the control register seen on the register port
	always_ff @(posedge mclk) begin
		if (sys_rst) ctl_reg <= '0;
		else if (reg_wr && reg_addr == OFS_CTRL) ctl_reg <= reg_wdata[CTRL_W-1:0];
	end

	AST_RST_QUIET: assert property ($fell(sys_rst) |-> !chrdy_oe && zws_n && ram_addr == 16'h0)
		else $error("outputs not quiet after reset");
	AST_RAM_EXCL: assert property (!(ram_we && ram_re))
		else $error("ram read and write together");
	AST_RAM_GRANT: assert property ((ram_we || ram_re) |-> ram_grant)
		else $error("ram strobe without grant");
	AST_ADDR_STEP: assert property (ram_re |=> ram_addr == $past(ram_addr) + 16'h1)
		else $error("buffer counter did not step");
	AST_OE_IDLE: assert property ((host_rd_n && host_wr_n) [*8] |-> !chrdy_oe)
		else $error("channel ready driven between accesses");
	AST_LOW_FIRST: assert property ($rose(chrdy_oe) |-> !chrdy_o)
		else $error("channel ready not driven low first");
	AST_RDY_DRIVEN: assert property ($rose(chrdy_o) |-> chrdy_oe)
		else $error("ready raised while not driven");
	AST_ZWS_GATE: assert property ($fell(zws_n) |-> ctl_reg[CTRL_ZWAIT] &&
		(!host_word || (ctl_reg[CTRL_WIDE] && slot_16bit && mem_16bit)))
		else $error("zero wait asserted while not allowed");
	AST_DATA_HOLD: assert property (chrdy_o && chrdy_oe && !host_rd_n |=> $stable(host_rdata))
		else $error("read data changed before strobe release");

	COV_READ: cover property ($rose(chrdy_o) && !host_rd_n);
	COV_WRITE: cover property ($rose(chrdy_o) && !host_wr_n);
	COV_ZWS: cover property ($fell(zws_n));
endmodule

bind hbmc_top hbmc_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
	.host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_word(host_word),
	.slot_16bit(slot_16bit), .mem_16bit(mem_16bit), .chrdy_o(chrdy_o), .chrdy_oe(chrdy_oe),
	.zws_n(zws_n), .ram_grant(ram_grant), .ram_we(ram_we), .ram_re(ram_re),
	.ram_rdata(ram_rdata), .ram_wdata(ram_wdata), .ram_addr(ram_addr));

// ---- test_host_buffer_memory_cache.sv ----
// Self-checking bench for the host buffer memory cache.
// Assumes the RAM model preloads each byte as its low address xor 5a.
module test_host_buffer_memory_cache;
	import hbmc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic        mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, stall_en = 0, ram_hold = 0;
	logic        host_rd_n = 1, host_wr_n = 1, host_word = 0, slot_16bit = 1, mem_16bit = 1;
	logic        ram_grant = 1, chrdy_o, chrdy_oe, zws_n, ram_we, ram_re;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0, host_addr = 16'h0, host_wdata = 16'h0;
	logic [15:0] reg_rdata, host_rdata, ram_addr, q;
	logic [7:0]  ram_rdata, ram_wdata;
	logic        z;
	int          err_count = 0, n_tests = 0, cyc = 0;

	hbmc_top uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
		.host_word(host_word), .slot_16bit(slot_16bit), .mem_16bit(mem_16bit),
		.host_rdata(host_rdata), .chrdy_o(chrdy_o), .chrdy_oe(chrdy_oe), .zws_n(zws_n),
		.ram_grant(ram_grant), .ram_rdata(ram_rdata), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re));
	hbmc_ram_model u_ram (.mclk(mclk), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata));

	// 100 ns clock
	always #50 mclk = ~mclk;

	// Grant gaps while stalling, plus the hang limit
	always @(posedge mclk) begin
		ram_grant <= !(stall_en && cyc[1]) && !ram_hold;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			summarize();
		end
	end

	function automatic logic [7:0] ex(input logic [15:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_w(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_r(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask

	// One host access held until ready is seen, then released
	task automatic host(input logic wr, input logic [15:0] a, input logic wd,
		input logic [15:0] d);
		int n;
		n = 0;
		z = 0;
		@(posedge mclk);
		host_addr <= a;
		host_word <= wd;
		host_wdata <= d;
		if (wr) host_wr_n <= 1'b0;
		else host_rd_n <= 1'b0;
		do begin
			@(negedge mclk);
			n++;
			if (zws_n === 1'b0) z = 1;
		end while (!(chrdy_oe === 1'b1 && chrdy_o === 1'b1) && n < 400);
		chk({15'h0, chrdy_o}, 16'h1);
		q = host_rdata;
		@(posedge mclk);
		host_rd_n <= 1'b1;
		host_wr_n <= 1'b1;
		repeat (16) @(posedge mclk);
		chk({15'h0, chrdy_oe}, 16'h0);
	endtask

	task automatic t_reset();
		reg_r(OFS_STATUS, q); chk(q, 16'h0);
		reg_r(OFS_CTRL, q); chk(q, 16'h0);
		reg_r(4'h5, q); chk(q, 16'h0);
		$display("t_reset done");
	endtask

	task automatic t_read();
		host(0, 16'h0010, 1, 16'h0); chk(q, {ex(16'h11), ex(16'h10)});
		host(0, 16'h0012, 1, 16'h0); chk(q, {ex(16'h13), ex(16'h12)});
		host(0, 16'h0014, 0, 16'h0); chk(q, {8'h00, ex(16'h14)});
		reg_r(OFS_HOSTCNT, q); chk(q, 16'h0015);
		$display("t_read done");
	endtask

	task automatic t_write();
		stall_en <= 1'b1;
		// RAM held off so the posted bytes stay queued
		ram_hold <= 1'b1;
		host(1, 16'h0040, 1, 16'hbeef);
		host(1, 16'h0042, 0, 16'h0077);
		reg_r(OFS_HOSTCNT, q); chk(q, 16'h0043);
		reg_r(OFS_STATUS, q); chk(q, 16'h0035);
		// Read miss meets pending writes, RAM freed while it flushes
		fork
			host(0, 16'h0040, 1, 16'h0);
			begin
				repeat (12) @(posedge mclk);
				ram_hold <= 1'b0;
			end
		join
		chk(q, 16'hbeef);
		host(0, 16'h0042, 0, 16'h0); chk(q, 16'h0077);
		chk({8'h0, u_ram.mem[16'h41]}, 16'h00be);
		stall_en <= 1'b0;
		$display("t_write done");
	endtask

	task automatic t_odd();
		reg_w(OFS_CTRL, 16'h0002);
		host(0, 16'h0080, 1, 16'h0); chk(q, {ex(16'h82), ex(16'h81)});
		host(0, 16'h0082, 1, 16'h0); chk(q, {ex(16'h84), ex(16'h83)});
		reg_w(OFS_CTRL, 16'h0000);
		$display("t_odd done");
	endtask

	task automatic t_zws();
		reg_w(OFS_CTRL, 16'h0005);
		host(0, 16'h0100, 1, 16'h0);
		host(0, 16'h0102, 1, 16'h0); chk({15'h0, z}, 16'h1);
		slot_16bit <= 1'b0;
		host(0, 16'h0104, 1, 16'h0); chk({15'h0, z}, 16'h0);
		host(0, 16'h0106, 0, 16'h0); chk({15'h0, z}, 16'h1);
		host(1, 16'h0200, 0, 16'h0033); chk({15'h0, z}, 16'h1);
		reg_w(OFS_CTRL, 16'h0004);
		host(1, 16'h0201, 0, 16'h0044); chk({15'h0, z}, 16'h0);
		slot_16bit <= 1'b1;
		$display("t_zws done");
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Reset for four cycles, then the scenarios
	initial begin
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_read();
		t_write();
		t_odd();
		t_zws();
		summarize();
	end
endmodule
